// ===== design/cptor_params.svh
// Register offsets, field layout, reset value and register count
`ifndef CPTOR_PARAMS_SVH
`define CPTOR_PARAMS_SVH
// What this block does
// - Trail time is automatic when bit 7 is 0, else bits 6:0.
// - With trail override clear, value writes are ignored; reads show automatic value.
// - With override set, value field is read/write and drives transmitter timing.
// - Exit time is automatic when bit 7 is 0, else bits 6:0.
// - Lp period is automatic when bit 7 is 0, else bits 6:0.
// - Registers sit on page 0x00 at indexes 0x46, 0x47, 0x48.
`define CPTOR_PAGE 8'h00
`define CPTOR_IDX_TRAIL 8'h46
`define CPTOR_IDX_EXIT 8'h47
`define CPTOR_IDX_LPX 8'h48
`define CPTOR_PAGE_LSB 8
`define CPTOR_OV_BIT 7
`define CPTOR_VAL_MSB 6
`define CPTOR_RESET_VAL 8'h00
`define CPTOR_NUM_REGS 3
`endif

// ===== design/cptor_pkg.sv
// Types shared by the timing override register bank
package cptor_pkg;
    typedef logic [6:0] cptor_val_t;
    typedef enum logic [1:0] {CPTOR_IDLE, CPTOR_RESP} cptor_state_t;
endpackage

// ===== design/cptor_field.sv
// One override register: select bit plus a 7-bit value field
`timescale 1ns/1ps
`include "cptor_params.svh"
module cptor_field (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Write side
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    // Timing
    input wire cptor_pkg::cptor_val_t autoVal,
    output cptor_pkg::cptor_val_t effVal,
    output logic [7:0] readVal
);
    logic overSel_r;
    cptor_pkg::cptor_val_t userVal_r;
    wire logic ovNext;
    assign ovNext = wrData[`CPTOR_OV_BIT];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            overSel_r <= 1'b0;
        else if (wrEn)
            overSel_r <= ovNext;
    end

    // The value is taken only when override is or becomes set in the
    // same write, so setting bit 7 and a value in one access works.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            userVal_r <= 7'h00;
        else if (wrEn && ovNext)
            userVal_r <= wrData[`CPTOR_VAL_MSB:0];
    end

    assign effVal = overSel_r ? userVal_r : autoVal;
    assign readVal = {overSel_r, effVal};
endmodule

// ===== design/cptor_regs.sv
// Avalon-MM slave holding the three D-PHY timing override registers
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cptor_params.svh"
module cptor_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [15:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // Automatic timing from the transmitter controller
    input wire cptor_pkg::cptor_val_t autoTrail,
    input wire cptor_pkg::cptor_val_t autoExit,
    input wire cptor_pkg::cptor_val_t autoLpPeriod,
    // Effective timing to the transmitter
    output cptor_pkg::cptor_val_t trailTime,
    output cptor_pkg::cptor_val_t exitTime,
    output cptor_pkg::cptor_val_t lpPeriod
);
    // Address is word index: page in [15:8], register in [7:0]
    cptor_pkg::cptor_state_t state_r;
    logic [31:0] rdData_r;
    logic wait_r;
    cptor_pkg::cptor_val_t trail_r, exit_r, lpx_r;
    wire logic [7:0] regIdx;
    wire logic pageHit;
    wire logic [2:0] hit;
    wire logic accept;
    wire logic [2:0] wrSel;
    wire cptor_pkg::cptor_val_t autoV [3];
    wire cptor_pkg::cptor_val_t effV [3];
    wire logic [7:0] rdV [3];
    wire logic [7:0] rdMux;

    assign regIdx = avsAddress[7:0];
    assign pageHit = avsAddress[15:`CPTOR_PAGE_LSB] == `CPTOR_PAGE;
    assign hit[0] = pageHit && regIdx == `CPTOR_IDX_TRAIL;
    assign hit[1] = pageHit && regIdx == `CPTOR_IDX_EXIT;
    assign hit[2] = pageHit && regIdx == `CPTOR_IDX_LPX;
    assign accept = state_r == cptor_pkg::CPTOR_IDLE;
    assign autoV[0] = autoTrail;
    assign autoV[1] = autoExit;
    assign autoV[2] = autoLpPeriod;
    // Registers are one byte wide, so only lane 0 carries a write
    assign wrSel = {3{accept && avsWrite && avsByteenable[0]}} & hit;
    assign rdMux = hit[0] ? rdV[0] : hit[1] ? rdV[1] :
                   hit[2] ? rdV[2] : 8'h00;

    genvar g;
    generate
        for (g = 0; g < `CPTOR_NUM_REGS; g++)
        begin : gReg
            cptor_field uField (
                .mclk(mclk),
                .arst_n(arst_n),
                .wrEn(wrSel[g]),
                .wrData(avsWritedata[7:0]),
                .autoVal(autoV[g]),
                .effVal(effV[g]),
                .readVal(rdV[g])
            );
        end
    endgenerate

    // Every access answers one cycle after it is seen; unmapped reads 0
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= cptor_pkg::CPTOR_IDLE;
        else
        begin
            case (state_r)
                cptor_pkg::CPTOR_IDLE:
                    if (avsRead || avsWrite)
                        state_r <= cptor_pkg::CPTOR_RESP;
                cptor_pkg::CPTOR_RESP:
                    state_r <= cptor_pkg::CPTOR_IDLE;
                default:
                    state_r <= cptor_pkg::CPTOR_IDLE;
            endcase
        end
    end

    // The write lands at the accepting edge, the same edge at which waitrequest
    // falls; the master holds its data until then, so nobody sees the
    // difference, and the answer never waits on the field update.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wait_r <= 1'b1;
        else
            wait_r <= !(accept && (avsRead || avsWrite));
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_r <= 32'h0000_0000;
        else if (accept && avsRead)
            rdData_r <= {24'h00_0000, rdMux};
    end

    // Registered outputs; one cycle behind the effective values
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trail_r <= 7'h00;
            exit_r <= 7'h00;
            lpx_r <= 7'h00;
        end
        else
        begin
            trail_r <= effV[0];
            exit_r <= effV[1];
            lpx_r <= effV[2];
        end
    end

    assign avsWaitrequest = wait_r;
    assign avsReaddata = rdData_r;
    assign trailTime = trail_r;
    assign exitTime = exit_r;
    assign lpPeriod = lpx_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence sOvWrite(int i);
        wrSel[i] && avsWritedata[`CPTOR_OV_BIT];
    endsequence

    // Write that clears override: the value bits must be dropped
    sequence sOvClear(int i);
        wrSel[i] && !avsWritedata[`CPTOR_OV_BIT];
    endsequence

    // Read of register i taken while the slave is idle
    sequence sRegRead(int i);
        accept && avsRead && hit[i];
    endsequence

    // Override write, the answer cycle, a quiet cycle, then the read
    sequence sWriteThenRead(int i);
        sOvWrite(i) ##2 !avsWrite ##1 sRegRead(i);
    endsequence

    a_trail_override: assert property (
        sOvWrite(0) |-> ##2 trailTime == $past(avsWritedata[6:0], 2))
        else $error("trail override value not applied");
    a_trail_auto: assert property (
        !rdV[0][7] |-> ##1 trailTime == $past(autoTrail))
        else $error("trail not automatic while override clear");
    a_value_rw: assert property (
        sWriteThenRead(1)
        |=> avsReaddata[7:0] == {1'b1, $past(avsWritedata[6:0], 4)})
        else $error("override value not read back");
    a_exit_auto: assert property (
        !rdV[1][7] |-> ##1 exitTime == $past(autoExit))
        else $error("exit not automatic while override clear");
    a_lpx_override: assert property (
        sOvWrite(2) |-> ##2 lpPeriod == $past(avsWritedata[6:0], 2))
        else $error("lp period override not applied");
    a_bus_answer: assert property (
        (accept && (avsRead || avsWrite)) |=> !avsWaitrequest ##1
        avsWaitrequest)
        else $error("bus answer not one cycle wide");
    a_reset_auto: assert property (
        $rose(arst_n) |-> !rdV[0][7] && !rdV[1][7] && !rdV[2][7])
        else $error("override set after reset");

    // Override behaviour on the remaining fields
    a_exit_override: assert property (
        sOvWrite(1) |-> ##2 exitTime == $past(avsWritedata[6:0], 2))
        else $error("exit override value not applied");
    a_lpx_auto: assert property (
        !rdV[2][7] |-> ##1 lpPeriod == $past(autoLpPeriod))
        else $error("lp period not automatic while override clear");
    a_trail_rw: assert property (
        sWriteThenRead(0)
        |=> avsReaddata[7:0] == {1'b1, $past(avsWritedata[6:0], 4)})
        else $error("trail override value not read back");
    a_lpx_rw: assert property (
        sWriteThenRead(2)
        |=> avsReaddata[7:0] == {1'b1, $past(avsWritedata[6:0], 4)})
        else $error("lp period override value not read back");

    // A set override loads the value in the very next cycle
    a_trail_load: assert property (
        sOvWrite(0) |=> rdV[0] == {1'b1, $past(avsWritedata[6:0])})
        else $error("trail override value not loaded");
    a_exit_load: assert property (
        sOvWrite(1) |=> rdV[1] == {1'b1, $past(avsWritedata[6:0])})
        else $error("exit override value not loaded");
    a_lpx_load: assert property (
        sOvWrite(2) |=> rdV[2] == {1'b1, $past(avsWritedata[6:0])})
        else $error("lp period override value not loaded");

    // Clearing override drops the written value at once
    a_trail_clear: assert property (
        sOvClear(0) |=> rdV[0] == {1'b0, autoTrail})
        else $error("trail value kept after override cleared");
    a_exit_clear: assert property (
        sOvClear(1) |=> rdV[1] == {1'b0, autoExit})
        else $error("exit value kept after override cleared");
    a_lpx_clear: assert property (
        sOvClear(2) |=> rdV[2] == {1'b0, autoLpPeriod})
        else $error("lp period value kept after override cleared");

    // With override clear the value field mirrors the automatic input
    a_trail_mirror: assert property (
        !rdV[0][7] |-> rdV[0][6:0] == autoTrail)
        else $error("trail readback not the automatic value");
    a_exit_mirror: assert property (
        !rdV[1][7] |-> rdV[1][6:0] == autoExit)
        else $error("exit readback not the automatic value");
    a_lpx_mirror: assert property (
        !rdV[2][7] |-> rdV[2][6:0] == autoLpPeriod)
        else $error("lp period readback not the automatic value");

    // An overridden value holds until software writes the register
    a_trail_hold: assert property (
        rdV[0][7] && !wrSel[0] |=> $stable(rdV[0]))
        else $error("trail override value drifted");
    a_exit_hold: assert property (
        rdV[1][7] && !wrSel[1] |=> $stable(rdV[1]))
        else $error("exit override value drifted");
    a_lpx_hold: assert property (
        rdV[2][7] && !wrSel[2] |=> $stable(rdV[2]))
        else $error("lp period override value drifted");

    // Effective timing follows the register one cycle later
    a_trail_eff: assert property (
        rdV[0][7] |-> ##1 trailTime == $past(rdV[0][6:0]))
        else $error("trail timing not taken from the override value");
    a_exit_eff: assert property (
        rdV[1][7] |-> ##1 exitTime == $past(rdV[1][6:0]))
        else $error("exit timing not taken from the override value");
    a_lpx_eff: assert property (
        rdV[2][7] |-> ##1 lpPeriod == $past(rdV[2][6:0]))
        else $error("lp period not taken from the override value");

    // Decode: each register at its own index, nothing elsewhere
    a_read_trail: assert property (
        sRegRead(0) |=> avsReaddata == {24'h00_0000, $past(rdV[0])})
        else $error("trail register not at its address");
    a_read_exit: assert property (
        sRegRead(1) |=> avsReaddata == {24'h00_0000, $past(rdV[1])})
        else $error("exit register not at its address");
    a_read_lpx: assert property (
        sRegRead(2) |=> avsReaddata == {24'h00_0000, $past(rdV[2])})
        else $error("lp period register not at its address");
    a_read_miss: assert property (
        accept && avsRead && !(|hit) |=> avsReaddata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_write_miss: assert property (
        accept && avsWrite && !(|hit) |=> $stable(rdV[0][7]) &&
            $stable(rdV[1][7]) && $stable(rdV[2][7]))
        else $error("unmapped write touched an override bit");
    a_read_side: assert property (
        accept && avsRead |=> $stable(rdV[0][7]) &&
            $stable(rdV[1][7]) && $stable(rdV[2][7]))
        else $error("read changed an override bit");
    a_one_select: assert property (
        $onehot0(wrSel))
        else $error("write selects more than one register");
    a_write_lane: assert property (
        (|wrSel) |-> avsByteenable[0])
        else $error("write taken without byte lane 0");
    a_lane_refused: assert property (
        accept && avsWrite && !avsByteenable[0] |=> $stable(rdV[0][7]) &&
            $stable(rdV[1][7]) && $stable(rdV[2][7]))
        else $error("write without lane 0 touched an override bit");

    // Handshake: one answer cycle per request, data held between reads
    a_wait_state: assert property (
        avsWaitrequest == accept)
        else $error("waitrequest out of step with the slave state");
    a_resp_short: assert property (
        !accept |=> accept)
        else $error("answer cycle longer than one clock");
    a_idle_wait: assert property (
        accept && !avsRead && !avsWrite |=> avsWaitrequest)
        else $error("waitrequest dropped with no request");
    a_read_stable: assert property (
        !(accept && avsRead) |=> $stable(avsReaddata))
        else $error("read data changed without a read");
    a_read_upper: assert property (
        avsReaddata[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");

    // Reset leaves the bus idle and the timing automatic
    a_reset_bus: assert property (
        $rose(arst_n) |-> avsWaitrequest && accept &&
            avsReaddata == 32'h0000_0000)
        else $error("bus not idle after reset");
    a_reset_timing: assert property (
        $rose(arst_n) |=> trailTime == $past(autoTrail) &&
            exitTime == $past(autoExit) &&
            lpPeriod == $past(autoLpPeriod))
        else $error("timing not automatic after reset");
endmodule

// ===== verif/cptor_phy_model.sv
// Transmitter controller stand-in supplying automatic timing values
`timescale 1ns/1ps
module cptor_phy_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Bench control
    input wire logic load,
    input wire logic [6:0] seedVal,
    // Automatic timing
    output cptor_pkg::cptor_val_t autoTrail,
    output cptor_pkg::cptor_val_t autoExit,
    output cptor_pkg::cptor_val_t autoLpPeriod
);
    // Values move only on load or reset, so a readback never races a change
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            {autoTrail, autoExit, autoLpPeriod} <= {7'h00, 7'h2A, 7'h11};
        else if (load)
            {autoTrail, autoExit, autoLpPeriod} <=
                {seedVal, seedVal ^ 7'h2A, seedVal + 7'h11};
    end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the timing override register bank
`timescale 1ns/1ps
module testbench;
    logic mclk, arst_n, avsRead, avsWrite, avsWaitrequest, load;
    logic [15:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [6:0] seedVal, v, s;
    logic [3:0] be;
    cptor_pkg::cptor_val_t autoTrail, autoExit, autoLpPeriod;
    cptor_pkg::cptor_val_t trailTime, exitTime, lpPeriod;
    int fails, cmp_count, i;
    int cyc = 0;
    cptor_regs u_dut (.mclk(mclk), .arst_n(arst_n),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsByteenable(be),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .autoTrail(autoTrail), .autoExit(autoExit),
        .autoLpPeriod(autoLpPeriod), .trailTime(trailTime),
        .exitTime(exitTime), .lpPeriod(lpPeriod));
    cptor_phy_model u_phy (.mclk(mclk), .arst_n(arst_n), .load(load),
        .seedVal(seedVal), .autoTrail(autoTrail), .autoExit(autoExit),
        .autoLpPeriod(autoLpPeriod));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // The sum wraps at 7 bits, as the stand-in's field does
    function automatic logic [31:0] autoOf(int n, logic [6:0] sv);
        logic [6:0] a;
        a = n == 0 ? sv : n == 1 ? sv ^ 7'h2A : 7'(sv + 7'h11);
        return {25'h0000000, a};
    endfunction
    function automatic logic [31:0] eff(int n);
        return 32'(n == 0 ? trailTime : n == 1 ? exitTime : lpPeriod);
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Request is held until waitrequest is seen low at a rising edge
    task automatic bus(logic wr, logic [15:0] a, logic [7:0] d);
        avsAddress <= a;
        avsWritedata <= {24'h000000, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge mclk);
        while (avsWaitrequest !== 1'b0)
            @(posedge mclk);
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end
    initial
    begin
        {avsRead, avsWrite, load, arst_n} = 4'h0;
        {avsAddress, avsWritedata, seedVal, s} = '0;
        be = 4'hF;
        {fails, cmp_count} = '0;
        void'($urandom(12));
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 3; i++)
        begin
            bus(1'b0, 16'h0046 + 16'(i), 8'h00);
            chk(rd, autoOf(i, s));
            chk(eff(i), autoOf(i, s));
        end
        for (int k = 0; k < 12; k++)
        begin
            i = k % 3;
            // Extremes of the value field go in among random ones
            v = k == 3 ? 7'h7F : k == 4 ? 7'h00 : 7'($urandom);
            bus(1'b1, 16'h0046 + 16'(i), {1'b1, v});
            bus(1'b0, 16'h0046 + 16'(i), 8'h00);
            chk(rd, {24'h000000, 1'b1, v});
            chk(eff(i), 32'(v));
            s = 7'($urandom);
            seedVal <= s;
            load <= 1'b1;
            @(posedge mclk);
            load <= 1'b0;
            repeat (3) @(posedge mclk);
            chk(eff(i), 32'(v));
            bus(1'b1, 16'h0046 + 16'(i), {1'b0, 7'($urandom)});
            bus(1'b0, 16'h0046 + 16'(i), 8'h00);
            chk(rd, autoOf(i, s));
            chk(eff(i), autoOf(i, s));
        end
        bus(1'b1, 16'h0146, 8'h85);
        bus(1'b0, 16'h0146, 8'h00);
        chk(rd, 32'h00000000);
        bus(1'b0, 16'h0045, 8'h00);
        chk(rd, 32'h00000000);
        bus(1'b0, 16'h0046, 8'h00);
        chk(rd, autoOf(0, s));
        // Lane 0 off: the write must be refused
        be <= 4'hE;
        bus(1'b1, 16'h0046, 8'h85);
        be <= 4'hF;
        bus(1'b0, 16'h0046, 8'h00);
        chk(rd, autoOf(0, s));
        // Reset in mid-run must clear a live override
        bus(1'b1, 16'h0048, 8'hD5);
        chk(eff(2), 32'h00000055);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        s = 7'h00;
        @(posedge mclk);
        for (i = 0; i < 3; i++)
        begin
            bus(1'b0, 16'h0046 + 16'(i), 8'h00);
            chk(rd, autoOf(i, s));
            chk(eff(i), autoOf(i, s));
        end
        conclude();
    end
endmodule
